// ### core/cmp_trig_pkg.sv
// Shared constants and types for the comparator trigger control and its timer end
package cmp_trig_pkg;
   // Selector geometry
   localparam int SEL_W = 3;
   localparam int NUM_CH = 8;
   localparam logic [2:0] CH_DAC12_OR_PIN = 3'h4;
   localparam logic [2:0] CH_BANDGAP = 3'h6;
   localparam logic [2:0] CH_DAC6 = 3'h7;
   // Reference DAC
   localparam int DAC_W = 6;
   localparam int DAC_STEPS = 64;
   localparam logic REF_HIGH_PIN = 1'b0;
   localparam logic REF_SUPPLY = 1'b1;
   // Channel source codes on the analog routing bus
   localparam logic [2:0] SRC_PIN = 3'h0;
   localparam logic [2:0] SRC_DAC12 = 3'h1;
   localparam logic [2:0] SRC_BANDGAP = 3'h2;
   localparam logic [2:0] SRC_DAC6 = 3'h3;
   // Control register offsets (device)
   localparam logic [3:0] OFS_CTRL = 4'h0;
   localparam logic [3:0] OFS_SEL = 4'h4;
   localparam logic [3:0] OFS_DAC = 4'h8;
   localparam logic [3:0] OFS_STAT = 4'hc;
   // Control field positions
   localparam int CTRL_EN = 0;
   localparam int CTRL_WINDOW = 1;
   localparam int CTRL_SAMPLE_SEL = 2;
   localparam int CTRL_PASS = 3;
   localparam int CTRL_TRIG = 4;
   localparam int CTRL_DAC_EN = 5;
   localparam int CTRL_REF = 6;
   localparam int CTRL_W = 7;
   localparam logic [6:0] CTRL_RST = 7'h00;
   // Timer register offsets
   localparam logic [3:0] OFS_TCTRL = 4'h0;
   localparam logic [3:0] OFS_TCMP = 4'h4;
   localparam logic [3:0] OFS_TSTAT = 4'h8;
   localparam int TCTRL_EN = 0;
   localparam int TCTRL_BYPASS = 1;
   localparam int TCTRL_PRE_LO = 2;
   localparam int PRE_W = 4;
   localparam int CNT_W = 16;
   // Power modes
   typedef enum logic [1:0] {PM_RUN, PM_STOP, PM_LLS, PM_DEEPEST} power_mode_t;
   // Trigger sequence
   typedef enum logic [1:0] {SEQ_OFF, SEQ_WAKE, SEQ_HOLD} seq_t;
   // Comparator analog settle time before a valid capture, ns
   localparam int INIT_NS = 200;
   localparam int CLK_NS = 8;
   localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
endpackage : cmp_trig_pkg

// ### core/cmp_trig_if.sv
// Two-stage trigger link between the low-power timer and the comparator control
`timescale 1ns/10ps
interface cmp_trig_if;
   logic wake;
   logic capture;
   modport timer_end (output wake, output capture);
   modport cmp_end (input wake, input capture);
endinterface : cmp_trig_if

// ### core/cmp_ctrl.sv
// Comparator digital control: selectors, reference DAC, trigger sequencing
`timescale 1ns/10ps
module cmp_ctrl (
   input wire logic core_clk,
   input wire logic rst_n,
   cmp_trig_if.cmp_end trig,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   input wire cmp_trig_pkg::power_mode_t power_mode,
   input wire logic analog_out,
   output logic [2:0] plus_sel,
   output logic [2:0] minus_sel,
   output logic [2:0] plus_src,
   output logic [2:0] minus_src,
   output logic [5:0] dac_code,
   output logic dac_ref,
   output logic cmp_power,
   output logic dac_power,
   output logic cmp_out,
   output logic adc_trig,
   output logic tpm_trig,
   output logic uart_ir
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [6:0] ctrl;
      logic [2:0] psel;
      logic [2:0] msel;
      logic [5:0] dac;
      cmp_trig_pkg::seq_t seq;
      logic [1:0] ana_s;
      logic cap_d;
      logic result;
      logic cmp_pwr;
      logic dac_pwr;
      logic [2:0] psrc;
      logic [2:0] msrc;
      logic [31:0] rdata;
      logic adc;
      logic tpm;
      logic ir;
   } state_t;

   state_t st_r;
   state_t st_nxt;

   // ------------------------------------------------------------
   // Channel map
   // ------------------------------------------------------------
   function automatic logic [2:0] src_of(input logic [2:0] ch);
      case (ch)
         cmp_trig_pkg::CH_DAC12_OR_PIN: src_of = cmp_trig_pkg::SRC_DAC12;
         cmp_trig_pkg::CH_BANDGAP: src_of = cmp_trig_pkg::SRC_BANDGAP;
         cmp_trig_pkg::CH_DAC6: src_of = cmp_trig_pkg::SRC_DAC6;
         default: src_of = cmp_trig_pkg::SRC_PIN;
      endcase
   endfunction : src_of

   logic avail;
   logic trig_mode;
   logic wake_l;
   logic cap_l;
   logic cap_rise;
   logic ana;

   always_comb begin
      st_nxt = st_r;
      avail = (power_mode != cmp_trig_pkg::PM_DEEPEST);
      trig_mode = st_r.ctrl[cmp_trig_pkg::CTRL_TRIG];
      // ------------------------------------------------------------
      // Input sampling
      // ------------------------------------------------------------
      // Trigger link shares this clock; only the analog level is synchronised
      st_nxt.ana_s = {st_r.ana_s[0], analog_out};
      wake_l = trig.wake;
      cap_l = trig.capture;
      ana = st_r.ana_s[1];
      st_nxt.cap_d = cap_l;
      cap_rise = cap_l & ~st_r.cap_d;

      // ------------------------------------------------------------
      // Register writes
      // ------------------------------------------------------------
      if (wr) begin
         case (addr)
            cmp_trig_pkg::OFS_CTRL: begin
               st_nxt.ctrl = wdata[cmp_trig_pkg::CTRL_W-1:0];
               st_nxt.ctrl[cmp_trig_pkg::CTRL_SAMPLE_SEL] = 1'b0;
               st_nxt.ctrl[cmp_trig_pkg::CTRL_WINDOW] = 1'b0;
               st_nxt.ctrl[cmp_trig_pkg::CTRL_PASS] = 1'b0;
            end
            cmp_trig_pkg::OFS_SEL: begin
               st_nxt.psel = wdata[2:0];
               st_nxt.msel = wdata[6:4];
            end
            cmp_trig_pkg::OFS_DAC: st_nxt.dac = wdata[cmp_trig_pkg::DAC_W-1:0];
            default: st_nxt.ctrl = st_r.ctrl;
         endcase
      end

      // ------------------------------------------------------------
      // Read data, one cycle after strobe
      // ------------------------------------------------------------
      st_nxt.rdata = 32'h0;
      if (rd) begin
         case (addr)
            cmp_trig_pkg::OFS_CTRL: st_nxt.rdata = {25'h0, st_r.ctrl};
            cmp_trig_pkg::OFS_SEL: st_nxt.rdata = {25'h0, st_r.msel, 1'b0, st_r.psel};
            cmp_trig_pkg::OFS_DAC: st_nxt.rdata = {26'h0, st_r.dac};
            cmp_trig_pkg::OFS_STAT: st_nxt.rdata = {27'h0, avail, st_r.seq, st_r.cmp_pwr, st_r.result};
            default: st_nxt.rdata = 32'h0;
         endcase
      end

      // ------------------------------------------------------------
      // Power and trigger sequence
      // ------------------------------------------------------------
      if (!avail) begin
         st_nxt.seq = cmp_trig_pkg::SEQ_OFF;
         st_nxt.cmp_pwr = 1'b0;
         st_nxt.dac_pwr = 1'b0;
         st_nxt.result = 1'b0;
      end else if (trig_mode) begin
         case (st_r.seq)
            cmp_trig_pkg::SEQ_OFF, cmp_trig_pkg::SEQ_HOLD: begin
               if (wake_l) begin
                  st_nxt.seq = cmp_trig_pkg::SEQ_WAKE;
               end
            end
            cmp_trig_pkg::SEQ_WAKE: begin
               if (cap_rise) begin
                  st_nxt.result = ana;
                  st_nxt.seq = cmp_trig_pkg::SEQ_HOLD;
               end
            end
            default: st_nxt.seq = cmp_trig_pkg::SEQ_OFF;
         endcase
         // power down between sequences, result held
         st_nxt.cmp_pwr = (st_nxt.seq == cmp_trig_pkg::SEQ_WAKE);
         st_nxt.dac_pwr = (st_nxt.seq == cmp_trig_pkg::SEQ_WAKE);
      end else begin
         st_nxt.seq = cmp_trig_pkg::SEQ_OFF;
         st_nxt.cmp_pwr = st_r.ctrl[cmp_trig_pkg::CTRL_EN];
         st_nxt.dac_pwr = st_r.ctrl[cmp_trig_pkg::CTRL_DAC_EN];
         // Continuous mode samples on the bus clock only
         st_nxt.result = st_r.cmp_pwr ? ana : 1'b0;
      end

      st_nxt.psrc = src_of(st_r.psel);
      st_nxt.msrc = src_of(st_r.msel);
      st_nxt.adc = st_nxt.result;
      st_nxt.tpm = st_nxt.result;
      st_nxt.ir = st_nxt.result;
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign rdata = st_r.rdata;
   assign plus_sel = st_r.psel;
   assign minus_sel = st_r.msel;
   assign plus_src = st_r.psrc;
   assign minus_src = st_r.msrc;
   assign dac_code = st_r.dac;
   assign dac_ref = st_r.ctrl[cmp_trig_pkg::CTRL_REF];
   assign cmp_power = st_r.cmp_pwr;
   assign dac_power = st_r.dac_pwr;
   assign cmp_out = st_r.result;
   assign adc_trig = st_r.adc;
   assign tpm_trig = st_r.tpm;
   assign uart_ir = st_r.ir;
endmodule : cmp_ctrl

// ### core/lp_timer.sv
// Low-power timer end producing the two-stage comparator trigger
`timescale 1ns/10ps
module lp_timer #(
   parameter int CNT_W = 16,
   parameter int PRE_W = 4
) (
   input wire logic core_clk,
   input wire logic rst_n,
   cmp_trig_if.timer_end trig,
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   output logic compare_flag
);
   typedef struct packed {
      logic en;
      logic bypass;
      logic [PRE_W-1:0] pre;
      logic [CNT_W-1:0] cmpv;
      logic [CNT_W-1:0] cnt;
      logic [15:0] div;
      logic flag;
      logic wake;
      logic cap;
      logic [16:0] gap;
      logic [31:0] rdata;
   } state_t;

   state_t st_r;
   state_t st_nxt;
   logic [16:0] half;
   logic [15:0] tick_at;
   logic tick;

   always_comb begin
      st_nxt = st_r;
      // Prescaler output period is 2^(pre+1) clocks
      tick_at = st_r.bypass ? 16'h0 : 16'((32'h2 << st_r.pre) - 32'h1);
      // bypass: half input period, one clock
      half = st_r.bypass ? 17'h1 : 17'((32'h1 << st_r.pre));
      tick = st_r.en && (st_r.div == tick_at);
      st_nxt.rdata = 32'h0;
      if (wr) begin
         case (addr)
            cmp_trig_pkg::OFS_TCTRL: begin
               st_nxt.en = wdata[cmp_trig_pkg::TCTRL_EN];
               st_nxt.bypass = wdata[cmp_trig_pkg::TCTRL_BYPASS];
               st_nxt.pre = wdata[cmp_trig_pkg::TCTRL_PRE_LO +: PRE_W];
            end
            cmp_trig_pkg::OFS_TCMP: st_nxt.cmpv = wdata[CNT_W-1:0];
            default: st_nxt.en = st_r.en;
         endcase
      end
      if (rd) begin
         case (addr)
            cmp_trig_pkg::OFS_TCTRL: st_nxt.rdata = 32'({st_r.pre, st_r.bypass, st_r.en});
            cmp_trig_pkg::OFS_TCMP: st_nxt.rdata = 32'(st_r.cmpv);
            cmp_trig_pkg::OFS_TSTAT: st_nxt.rdata = 32'({st_r.cnt, 15'h0, st_r.flag});
            default: st_nxt.rdata = 32'h0;
         endcase
      end
      // Clear first so a set in the same cycle wins
      if (wr && (addr == cmp_trig_pkg::OFS_TSTAT) && wdata[0]) begin
         st_nxt.flag = 1'b0;
      end
      if (!st_r.en) begin
         st_nxt.cnt = '0;
         st_nxt.div = '0;
         st_nxt.wake = 1'b0;
         st_nxt.cap = 1'b0;
         st_nxt.gap = '0;
      end else begin
         st_nxt.div = tick ? 16'h0 : st_r.div + 16'h1;
         st_nxt.cap = 1'b0;
         if (tick) begin
            if (st_r.cnt == st_r.cmpv) begin
               st_nxt.cnt = '0;
               st_nxt.flag = 1'b1;
               st_nxt.wake = 1'b1;
               st_nxt.gap = half;
            end else begin
               st_nxt.cnt = st_r.cnt + 1'b1;
            end
         end
         // capture half a prescaler period later
         if (st_r.gap != '0) begin
            st_nxt.gap = st_r.gap - 17'h1;
            if (st_r.gap == 17'h1) begin
               st_nxt.cap = 1'b1;
               st_nxt.wake = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign trig.wake = st_r.wake;
   assign trig.capture = st_r.cap;
   assign rdata = st_r.rdata;
   assign compare_flag = st_r.flag;
endmodule : lp_timer

// ### verif/cmp_trig_checker.sv
// Assertions on the trigger link between the timer and the comparator control
`timescale 1ns/10ps
module cmp_trig_checker (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic wake,
   input wire logic capture,
   input wire logic compare_flag,
   input wire cmp_trig_pkg::power_mode_t power_mode,
   input wire logic cmp_power,
   input wire logic dac_power,
   input wire logic cmp_out,
   input wire logic adc_trig,
   input wire logic tpm_trig,
   input wire logic uart_ir
);
   // ----------------------------------------
   // Link and power properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   sequence s_wake_drop; wake ##1 !wake; endsequence
   // Three cycles so the power-down latency is not pinned exactly
   sequence s_deep_run; (power_mode == cmp_trig_pkg::PM_DEEPEST)[*3]; endsequence
   property p_wake_flag; $rose(wake) |-> compare_flag; endproperty
   property p_flag_wake; $rose(compare_flag) |-> wake; endproperty
   property p_capture_prior; $rose(capture) |-> $past(wake) && !wake; endproperty
   property p_wake_end; s_wake_drop |-> capture; endproperty
   property p_capture_pulse; capture |=> !capture; endproperty
   property p_fanout; cmp_out == adc_trig && cmp_out == tpm_trig && cmp_out == uart_ir; endproperty
   property p_deep_power; s_deep_run |-> !cmp_power && !dac_power; endproperty
   property p_deep_result; s_deep_run |-> !cmp_out; endproperty
   a_wake_flag: assert property (p_wake_flag) else $error("wake rose without compare flag");
   a_flag_wake: assert property (p_flag_wake) else $error("compare flag rose without wake");
   a_capture_prior: assert property (p_capture_prior) else $error("capture not after wake");
   a_wake_end: assert property (p_wake_end) else $error("wake ended without capture");
   a_capture_pulse: assert property (p_capture_pulse) else $error("capture longer than one cycle");
   a_fanout: assert property (p_fanout) else $error("result fanout differs");
   a_deep_power: assert property (p_deep_power) else $error("powered in deepest mode");
   a_deep_result: assert property (p_deep_result) else $error("result in deepest mode");
endmodule : cmp_trig_checker

// ### verif/testbench.sv
// Self-checking bench joining the comparator control and the timer end
`timescale 1ns/10ps
module testbench;
   logic core_clk, rst_n, c_wr, c_rd, t_wr, t_rd, analog_out;
   logic [3:0] addr;
   logic [31:0] wdata, c_rdata, t_rdata, v;
   cmp_trig_pkg::power_mode_t power_mode;
   logic [2:0] plus_sel, minus_sel, plus_src, minus_src;
   logic [5:0] dac_code;
   logic dac_ref, cmp_power, dac_power, cmp_out, adc_trig, tpm_trig, uart_ir, compare_flag;
   int n_errors = 0;
   int checked = 0;
   int cyc = 0;
   cmp_trig_if cmp_trig_if_i ();
   cmp_ctrl cmp_ctrl_i (.core_clk, .rst_n, .trig(cmp_trig_if_i), .addr, .wdata, .wr(c_wr), .rd(c_rd),
      .rdata(c_rdata), .power_mode, .analog_out, .plus_sel, .minus_sel, .plus_src, .minus_src, .dac_code,
      .dac_ref, .cmp_power, .dac_power, .cmp_out, .adc_trig, .tpm_trig, .uart_ir);
   lp_timer lp_timer_i (.core_clk, .rst_n, .trig(cmp_trig_if_i), .addr, .wdata, .wr(t_wr), .rd(t_rd),
      .rdata(t_rdata), .compare_flag);
   cmp_trig_checker cmp_trig_checker_i (.core_clk, .rst_n, .wake(cmp_trig_if_i.wake),
      .capture(cmp_trig_if_i.capture), .compare_flag, .power_mode, .cmp_power, .dac_power, .cmp_out,
      .adc_trig, .tpm_trig, .uart_ir);
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : chk
   task automatic bus_wr(input bit tgt, input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      c_wr <= !tgt;
      t_wr <= tgt;
      @(posedge core_clk);
      c_wr <= 1'b0;
      t_wr <= 1'b0;
      repeat (2) @(negedge core_clk);
   endtask : bus_wr
   task automatic bus_rd(input bit tgt, input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      c_rd <= !tgt;
      t_rd <= tgt;
      @(posedge core_clk);
      c_rd <= 1'b0;
      t_rd <= 1'b0;
      @(negedge core_clk);
      d = tgt ? t_rdata : c_rdata;
   endtask : bus_rd
   task automatic set_analog(input logic a);
      @(posedge core_clk);
      analog_out <= a;
      repeat (6) @(negedge core_clk);
   endtask : set_analog
   function automatic logic [2:0] src_of(input logic [2:0] ch);
      return ch == 3'h6 ? cmp_trig_pkg::SRC_BANDGAP : ch == 3'h7 ? cmp_trig_pkg::SRC_DAC6 : cmp_trig_pkg::SRC_PIN;
   endfunction : src_of
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_select();
      logic [2:0] p;
      for (int ch = 0; ch < 8; ch++) begin
         p = 3'(ch);
         bus_wr(0, cmp_trig_pkg::OFS_SEL, {25'h0, 3'h7 - p, 1'b0, p});
         chk("plus_sel", 32'(p), 32'(plus_sel));
         chk("minus_sel", 32'(3'h7 - p), 32'(minus_sel));
         // Channel 4 may be the converter or a pin, so its source is not pinned
         if (p != 3'h4) chk("plus_src", 32'(src_of(p)), 32'(plus_src));
         if (p != 3'h3) chk("minus_src", 32'(src_of(3'h7 - p)), 32'(minus_src));
      end
   endtask : t_select
   task automatic t_dac_ref();
      for (int i = 0; i < 2; i++) begin
         bus_wr(0, cmp_trig_pkg::OFS_DAC, i ? 32'h3f : 32'h0);
         bus_wr(0, cmp_trig_pkg::OFS_CTRL, i ? 32'h40 : 32'h0);
         chk("dac_code", i ? 32'h3f : 32'h0, 32'(dac_code));
         chk("dac_ref", 32'(i ? cmp_trig_pkg::REF_SUPPLY : cmp_trig_pkg::REF_HIGH_PIN), 32'(dac_ref));
      end
   endtask : t_dac_ref
   task automatic t_forced();
      bus_wr(0, cmp_trig_pkg::OFS_CTRL, 32'h2f);
      bus_rd(0, cmp_trig_pkg::OFS_CTRL, v);
      chk("ctrl", 32'h21, v);
      bus_rd(0, 4'h2, v);
      chk("unmapped", 32'h0, v);
   endtask : t_forced
   task automatic t_live_deep();
      set_analog(1'b1);
      chk("cmp_power", 32'h1, 32'(cmp_power));
      chk("uart_ir", 32'h1, 32'(uart_ir));
      @(posedge core_clk);
      power_mode <= cmp_trig_pkg::PM_DEEPEST;
      set_analog(1'b1);
      chk("deep_power", 32'h0, 32'(dac_power));
      chk("deep_out", 32'h0, 32'(cmp_out));
      @(posedge core_clk);
      power_mode <= cmp_trig_pkg::PM_RUN;
   endtask : t_live_deep
   task automatic t_trigger(input logic bypass, input logic [3:0] pre, input int gap, input logic res);
      int n;
      bus_wr(0, cmp_trig_pkg::OFS_CTRL, 32'h10);
      set_analog(res);
      bus_wr(1, cmp_trig_pkg::OFS_TCMP, 32'h3);
      bus_wr(1, cmp_trig_pkg::OFS_TCTRL, {26'h0, pre, bypass, 1'b1});
      for (n = 0; cmp_trig_if_i.wake !== 1'b1 && n < 2000; n++) @(negedge core_clk);
      for (n = 0; cmp_trig_if_i.capture !== 1'b1 && n < 2000; n++) begin
         @(negedge core_clk);
         if (n == 6 && gap > 7) chk("wake_power", 32'h1, 32'(cmp_power));
      end
      chk("gap", 32'(gap), 32'(n));
      if (!bypass) chk("settle_gap", 32'h1, 32'(n > cmp_trig_pkg::INIT_CYC));
      bus_wr(1, cmp_trig_pkg::OFS_TCTRL, 32'h0);
      bus_rd(1, cmp_trig_pkg::OFS_TSTAT, v);
      chk("flag", 32'h1, 32'(v[0]));
      set_analog(!res);
      chk("held", 32'(res), 32'(cmp_out));
      chk("off", 32'h0, 32'(cmp_power));
      bus_wr(1, cmp_trig_pkg::OFS_TSTAT, 32'h1);
      chk("flag_clear", 32'h0, 32'(compare_flag));
   endtask : t_trigger
   task automatic summarize();
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize
   // ----------------------------------------
   // Clock, reset, sequence
   // ----------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   // Ceiling well above the longest scenario so a hung wait still reports
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_errors++;
         summarize();
      end
   end
   initial begin
      {rst_n, c_wr, c_rd, t_wr, t_rd, analog_out, addr, wdata} = '0;
      power_mode = cmp_trig_pkg::PM_RUN;
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      t_select();
      t_dac_ref();
      t_forced();
      t_live_deep();
      // Prescaled gap of 32 clocks clears the comparator settle time
      t_trigger(1'b0, 4'h5, 32, 1'b1);
      // Bypass gap is one clock; a one-cycle capture pulse must still land
      t_trigger(1'b1, 4'h0, 1, 1'b0);
      summarize();
   end
endmodule : testbench
